// ---- inc/pmct_pkg.sv ----
package pmct_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and time base
  localparam int unsigned CLK_HZ  = 20000000;
  localparam int unsigned TICK_HZ = 3579545;
  localparam int unsigned PHASE_W = 25;
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(TICK_HZ);
  localparam logic [PHASE_W-1:0] PHASE_MOD  = PHASE_W'(CLK_HZ);

  ////////////////////////////////////////////////////////////////////////
  // Address map (byte addresses, each base 32-bit aligned)
  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] CTL_A_BASE = 16'h0404;
  localparam logic [ADDR_W-1:0] CTL_B_BASE = 16'h0408;
  localparam logic [ADDR_W-1:0] TMR_BASE   = 16'h0410;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned CTL_W        = 16;
  localparam int unsigned ROUTE_BIT    = 0;
  localparam int unsigned BM_WAKE_BIT  = 1;
  localparam int unsigned LOCK_BIT     = 2;
  localparam int unsigned TYPE_LSB     = 10;
  localparam int unsigned TYPE_W       = 3;
  localparam int unsigned GO_BIT       = 13;
  localparam logic [CTL_W-1:0] CTL_RESET  = 16'h0000;
  // Bits implemented in each block
  localparam logic [CTL_W-1:0] CTL_A_MASK = 16'h3c07;
  localparam logic [CTL_W-1:0] CTL_B_MASK = 16'h1c00;

  ////////////////////////////////////////////////////////////////////////
  // Timer
  localparam int unsigned CNT_W       = 32;
  localparam logic        TIMER_32BIT = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MASK  =
    TIMER_32BIT ? 32'hffff_ffff : 32'h00ff_ffff;
  localparam int unsigned CNT_MSB = TIMER_32BIT ? 31 : 23;

  ////////////////////////////////////////////////////////////////////////
  // Access sizes and pin synchronisers
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'b00,
    SZ_WORD  = 2'b01,
    SZ_DWORD = 2'b10
  } pmct_size_t;

  localparam int unsigned PIN_N = 4;
  localparam int unsigned PIN_IDLE = 0;
  localparam int unsigned PIN_BMREQ = 1;
  localparam int unsigned PIN_WAKE = 2;
  localparam int unsigned PIN_SYSCLK = 3;

  typedef enum logic [1:0] {
    ST_WORK   = 2'b00,
    ST_ENTER  = 2'b01,
    ST_SLEEP  = 2'b11,
    ST_RESUME = 2'b10
  } pmct_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    pmct_size_t        size;
    logic              wr;
    logic              rd;
    logic [31:0]       wdata;
  } pmct_io_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        rvalid;
  } pmct_io_rsp_t;

  typedef struct packed {
    logic [PIN_N-1:0]  pin_meta;
    logic [PIN_N-1:0]  pin_sync;
    logic              route;
    logic              bm_wake;
    logic [TYPE_W-1:0] type_a;
    logic [TYPE_W-1:0] type_b;
    pmct_state_t       state;
    logic              sleep_pulse;
    logic              lock_pulse;
    logic              wake_pulse;
    logic              fw_flag;
    logic              carry_flag;
    logic [PHASE_W-1:0] phase;
    logic [CNT_W-1:0]  count;
    pmct_io_rsp_t      rsp;
  } pmct_regs_t;

endpackage

// ---- hdl/pmct_top.sv ----
module pmct_top
  import pmct_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire pmct_pkg::pmct_io_req_t  io_req,
  output      pmct_pkg::pmct_io_rsp_t  io_rsp,
  input  wire logic                    route_set,
  input  wire logic                    route_clear,
  input  wire logic                    firmware_event_enable,
  input  wire logic                    firmware_flag_clear,
  input  wire logic                    timer_carry_irq_enable,
  input  wire logic                    timer_carry_clear,
  input  wire logic                    deep_idle_pin,
  input  wire logic                    busmaster_req_pin,
  input  wire logic                    wake_pin,
  input  wire logic                    sysclk_running_pin,
  output      logic                    event_route_select,
  output      logic                    busmaster_idle_wake,
  output      logic                    processor_wake,
  output      logic                    lock_release_notify,
  output      logic                    firmware_event_flag,
  output      logic                    timer_carry_flag,
  output      logic                    timer_width_flag,
  output      logic                    os_pm_interrupt,
  output      logic                    firmware_mgmt_interrupt,
  output      logic [TYPE_W-1:0]       sleep_type_sel_a,
  output      logic [TYPE_W-1:0]       sleep_type_sel_b,
  output      logic                    sleep_go,
  output      logic                    working_state,
  output      logic [CNT_W-1:0]        timer_count
);

  import pmct_pkg::*;

  pmct_regs_t s;
  pmct_regs_t next_s;

  ////////////////////////////////////////////////////////////////////////
  // Access decode
  logic [ADDR_W-1:0] off_a;
  logic [ADDR_W-1:0] off_b;
  logic              hit_a;
  logic              hit_b;
  logic              hit_t;
  logic [1:0]        lane_en;
  logic [CTL_W-1:0]  lane_data;
  logic [CTL_W-1:0]  view_a;
  logic [CTL_W-1:0]  view_b;
  logic [CTL_W-1:0]  wr_a;
  logic [CTL_W-1:0]  wr_b;
  logic [CTL_W-1:0]  be_bits;
  logic [31:0]       rd_value;

  always_comb begin
    off_a = io_req.addr - CTL_A_BASE;
    off_b = io_req.addr - CTL_B_BASE;
    hit_a = 1'b0;
    hit_b = 1'b0;
    hit_t = 1'b0;
    lane_en = 2'b00;
    lane_data = '0;
    // Byte at +0 or +1, word only at +0
    if (io_req.size == SZ_BYTE && off_a < 16'h0002) begin
      hit_a = 1'b1;
    end else if (io_req.size == SZ_WORD && off_a == 16'h0000) begin
      hit_a = 1'b1;
    end
    if (io_req.size == SZ_BYTE && off_b < 16'h0002) begin
      hit_b = 1'b1;
    end else if (io_req.size == SZ_WORD && off_b == 16'h0000) begin
      hit_b = 1'b1;
    end
    // Timer answers only a whole 32-bit read
    if (io_req.size == SZ_DWORD && io_req.addr == TMR_BASE) begin
      hit_t = 1'b1;
    end
    if (io_req.size == SZ_WORD) begin
      lane_en = 2'b11;
      lane_data = io_req.wdata[15:0];
    end else if (io_req.addr[0]) begin
      lane_en = 2'b10;
      lane_data = {io_req.wdata[7:0], 8'h00};
    end else begin
      lane_en = 2'b01;
      lane_data = {8'h00, io_req.wdata[7:0]};
    end
  end

  assign be_bits = {{8{lane_en[1]}}, {8{lane_en[0]}}};

  // Write-only, reserved and ignored bits stay zero in the view
  always_comb begin
    view_a = '0;
    view_a[ROUTE_BIT] = s.route;
    view_a[BM_WAKE_BIT] = s.bm_wake;
    view_a[TYPE_LSB +: TYPE_W] = s.type_a;
    view_a = view_a & CTL_A_MASK;
    view_b = '0;
    view_b[TYPE_LSB +: TYPE_W] = s.type_b;
    view_b = view_b & CTL_B_MASK;
  end

  // Effective write bits per block, absent bits dropped
  assign wr_a = (io_req.wr && hit_a) ? (lane_data & be_bits & CTL_A_MASK) : '0;
  assign wr_b = (io_req.wr && hit_b) ? (lane_data & be_bits & CTL_B_MASK) : '0;

  always_comb begin
    rd_value = '0;
    if (hit_a) begin
      rd_value = io_req.addr[0] ? {24'h000000, view_a[15:8]} : {16'h0000, view_a};
      if (io_req.size == SZ_BYTE && !io_req.addr[0]) begin
        rd_value = {24'h000000, view_a[7:0]};
      end
    end else if (hit_b) begin
      rd_value = io_req.addr[0] ? {24'h000000, view_b[15:8]} : {16'h0000, view_b};
      if (io_req.size == SZ_BYTE && !io_req.addr[0]) begin
        rd_value = {24'h000000, view_b[7:0]};
      end
    end else if (hit_t) begin
      rd_value = s.count & CNT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  logic [PHASE_W:0]   phase_sum;
  logic               tick;
  logic               counting;
  logic [CNT_W-1:0]   count_inc;
  logic               bm_write_en;
  logic               type_a_en;
  logic               type_b_en;

  always_comb begin
    next_s = s;
    phase_sum = {1'b0, s.phase} + {1'b0, PHASE_STEP};
    tick = 1'b0;
    counting = 1'b0;
    count_inc = '0;
    bm_write_en = io_req.wr && hit_a && lane_en[0];
    type_a_en = io_req.wr && hit_a && lane_en[1];
    type_b_en = io_req.wr && hit_b && lane_en[1];

    // Two-flop pin synchronisers
    next_s.pin_meta = {sysclk_running_pin, wake_pin, busmaster_req_pin, deep_idle_pin};
    next_s.pin_sync = s.pin_meta;

    // Routing bit: hardware only, set wins over clear
    if (route_set) begin
      next_s.route = 1'b1;
    end else if (route_clear) begin
      next_s.route = 1'b0;
    end

    if (bm_write_en) begin
      next_s.bm_wake = wr_a[BM_WAKE_BIT];
    end
    if (type_a_en) begin
      next_s.type_a = wr_a[TYPE_LSB +: TYPE_W];
    end
    if (type_b_en) begin
      next_s.type_b = wr_b[TYPE_LSB +: TYPE_W];
    end

    // Deep-idle wake on bus master request
    next_s.wake_pulse = s.bm_wake && s.pin_sync[PIN_BMREQ] && s.pin_sync[PIN_IDLE];

    // Write-only strobes, never stored in the view
    next_s.lock_pulse = wr_a[LOCK_BIT];
    next_s.sleep_pulse = 1'b0;

    // Firmware event flag, set wins over clear
    if (s.lock_pulse) begin
      next_s.fw_flag = 1'b1;
    end else if (firmware_flag_clear) begin
      next_s.fw_flag = 1'b0;
    end

    // Sleep sequencing
    case (s.state)
      ST_WORK: begin
        if (wr_a[GO_BIT]) begin
          next_s.state = ST_ENTER;
        end
      end
      ST_ENTER: begin
        next_s.sleep_pulse = 1'b1;
        next_s.state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (s.pin_sync[PIN_WAKE]) begin
          next_s.state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        next_s.state = ST_WORK;
      end
      default: begin
        next_s.state = ST_WORK;
      end
    endcase

    // Time base and counter; count held outside working state
    counting = (s.state == ST_WORK) && s.pin_sync[PIN_SYSCLK];
    if (counting) begin
      if (phase_sum >= {1'b0, PHASE_MOD}) begin
        tick = 1'b1;
        next_s.phase = PHASE_W'(phase_sum - {1'b0, PHASE_MOD});
      end else begin
        next_s.phase = phase_sum[PHASE_W-1:0];
      end
    end
    if (tick) begin
      count_inc = (s.count + 32'h0000_0001) & CNT_MASK;
      next_s.count = count_inc;
    end

    // Carry flag, set wins over clear
    if (tick && (count_inc[CNT_MSB] != s.count[CNT_MSB])) begin
      next_s.carry_flag = 1'b1;
    end else if (timer_carry_clear) begin
      next_s.carry_flag = 1'b0;
    end

    // Registered read answer
    next_s.rsp.rvalid = io_req.rd;
    next_s.rsp.rdata = io_req.rd ? rd_value : '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '{
        pin_meta:    '0,
        pin_sync:    '0,
        route:       CTL_RESET[ROUTE_BIT],
        bm_wake:     CTL_RESET[BM_WAKE_BIT],
        type_a:      CTL_RESET[TYPE_LSB +: TYPE_W],
        type_b:      CTL_RESET[TYPE_LSB +: TYPE_W],
        state:       ST_WORK,
        sleep_pulse: 1'b0,
        lock_pulse:  1'b0,
        wake_pulse:  1'b0,
        fw_flag:     1'b0,
        carry_flag:  1'b0,
        phase:       '0,
        count:       CNT_RESET,
        rsp:         '0
      };
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  logic carry_event;
  logic fw_event;

  assign carry_event = s.carry_flag && timer_carry_irq_enable;
  assign fw_event = s.fw_flag && firmware_event_enable;

  assign io_rsp = s.rsp;
  assign event_route_select = s.route;
  assign busmaster_idle_wake = s.bm_wake;
  assign processor_wake = s.wake_pulse;
  assign lock_release_notify = s.lock_pulse;
  assign firmware_event_flag = s.fw_flag;
  assign timer_carry_flag = s.carry_flag;
  assign timer_width_flag = TIMER_32BIT;
  assign os_pm_interrupt = s.route && carry_event;
  assign firmware_mgmt_interrupt = (!s.route && carry_event) || fw_event;
  assign sleep_type_sel_a = s.type_a;
  assign sleep_type_sel_b = s.type_b;
  assign sleep_go = s.sleep_pulse;
  assign working_state = (s.state == ST_WORK);
  assign timer_count = s.count & CNT_MASK;

endmodule

// ---- testbench/pmct_assertions.sv ----
module pmct_checker
  import pmct_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire pmct_pkg::pmct_io_req_t io_req,
  input wire pmct_pkg::pmct_io_rsp_t io_rsp,
  input wire logic                   route_set,
  input wire logic                   route_clear,
  input wire logic                   timer_carry_irq_enable,
  input wire logic                   event_route_select,
  input wire logic                   timer_carry_flag,
  input wire logic                   os_pm_interrupt,
  input wire logic                   lock_release_notify,
  input wire logic                   sleep_go,
  input wire logic                   working_state,
  input wire logic                   timer_width_flag,
  input wire logic [CNT_W-1:0]       timer_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence lock_wr;
    io_req.wr && io_req.addr == CTL_A_BASE && io_req.size == SZ_WORD && io_req.wdata[LOCK_BIT];
  endsequence
  sequence go_wr;
    io_req.wr && io_req.addr == CTL_A_BASE && io_req.size == SZ_WORD && io_req.wdata[GO_BIT]
      && working_state;
  endsequence

  AST_RD_ANSWER: assert property (io_req.rd |=> io_rsp.rvalid)
    else $error("read not answered");
  AST_RSV_ZERO: assert property (io_rsp.rvalid && $past(io_req.addr) != TMR_BASE
    |-> io_rsp.rdata[31:13] == 19'h0)
    else $error("reserved bits not zero");
  AST_ROUTE_SET: assert property (route_set |=> event_route_select)
    else $error("route not set");
  AST_ROUTE_KEEP: assert property (!route_set && !route_clear |=> $stable(event_route_select))
    else $error("route changed by write");
  AST_OS_IRQ: assert property (os_pm_interrupt
    == (event_route_select && timer_carry_flag && timer_carry_irq_enable))
    else $error("os interrupt wrong");
  AST_LOCK: assert property (lock_wr |=> lock_release_notify ##1 !lock_release_notify)
    else $error("lock pulse wrong");
  AST_GO: assert property (go_wr |=> ##1 (sleep_go && !working_state) ##1 !sleep_go)
    else $error("sleep entry wrong");
  AST_HOLD: assert property (!working_state |=> $stable(timer_count))
    else $error("count moved in sleep");
  AST_STEP: assert property (timer_count == $past(timer_count)
    || timer_count == $past(timer_count) + 32'h1)
    else $error("count step wrong");
  AST_WIDTH: assert property (timer_width_flag == TIMER_32BIT)
    else $error("width flag wrong");
  AST_CARRY: assert property (timer_count[CNT_MSB] != $past(timer_count[CNT_MSB])
    |-> timer_carry_flag)
    else $error("carry flag not set on top bit toggle");
endmodule

bind pmct_top pmct_checker u_chk (
  .core_clk              (core_clk),
  .rst_n                 (rst_n),
  .io_req                (io_req),
  .io_rsp                (io_rsp),
  .route_set             (route_set),
  .route_clear           (route_clear),
  .timer_carry_irq_enable(timer_carry_irq_enable),
  .event_route_select    (event_route_select),
  .timer_carry_flag      (timer_carry_flag),
  .os_pm_interrupt       (os_pm_interrupt),
  .lock_release_notify   (lock_release_notify),
  .sleep_go              (sleep_go),
  .working_state         (working_state),
  .timer_width_flag      (timer_width_flag),
  .timer_count           (timer_count)
);

// ---- testbench/pmct_host.sv ----
module pmct_host
  import pmct_pkg::*;
(
  input  wire logic                   core_clk,
  output      pmct_pkg::pmct_io_req_t io_req,
  input  wire pmct_pkg::pmct_io_rsp_t io_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial io_req = '0;

  // One transfer, strobe held over the taking edge only
  task automatic access(input logic [15:0] a, input pmct_size_t s, input logic w,
                        input logic [31:0] d, output logic [31:0] q, output logic v);
    @(posedge core_clk);
    #1;
    io_req.addr = a;
    io_req.size = s;
    io_req.wdata = d;
    io_req.wr = w;
    io_req.rd = !w;
    @(posedge core_clk);
    #1;
    q = io_rsp.rdata;
    v = io_rsp.rvalid;
    if (a != TMR_BASE)
      q[9] = 1'b0;
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
    io_req.addr = ~a;
    io_req.wdata = ~d;
  endtask
endmodule

// ---- testbench/tb_pm_control_and_timer.sv ----
module tb_pm_control_and_timer
  import pmct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, rset, rclr, fw_en, fw_clr, irq_en, c_clr, idle, bmr, wake, sclk;
  logic route_q, bmw, pwake, lock_q, fw_f, car_f, wid, os_i, fw_i, go_q, work;
  logic [2:0]  ta_q, tb_q, ta, tb;
  logic [31:0] cnt, q;
  logic [15:0] ma, mb, a, d;
  logic        mroute;
  pmct_io_req_t io_req;
  pmct_io_rsp_t io_rsp;
  int fails, cmp_count, cyc, k;

  pmct_host u_host (.core_clk(core_clk), .io_req(io_req), .io_rsp(io_rsp));
  pmct_top DUT (.core_clk(core_clk), .rst_n(rst_n), .io_req(io_req), .io_rsp(io_rsp),
    .route_set(rset), .route_clear(rclr), .firmware_event_enable(fw_en),
    .firmware_flag_clear(fw_clr), .timer_carry_irq_enable(irq_en), .timer_carry_clear(c_clr),
    .deep_idle_pin(idle), .busmaster_req_pin(bmr), .wake_pin(wake),
    .sysclk_running_pin(sclk), .event_route_select(route_q), .busmaster_idle_wake(bmw),
    .processor_wake(pwake), .lock_release_notify(lock_q), .firmware_event_flag(fw_f),
    .timer_carry_flag(car_f), .timer_width_flag(wid), .os_pm_interrupt(os_i),
    .firmware_mgmt_interrupt(fw_i), .sleep_type_sel_a(ta_q), .sleep_type_sel_b(tb_q),
    .sleep_go(go_q), .working_state(work), .timer_count(cnt));

  always #25 core_clk = ~core_clk;

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Model of the stored control bits, byte lanes honoured
  function automatic void mwr(logic [15:0] ad, pmct_size_t s, logic [15:0] dv);
    logic [15:0] m, v;
    m = (s == SZ_BYTE) ? (16'h00ff << (ad[0] * 8)) : 16'hffff;
    v = (dv << (ad[0] * 8)) & m;
    if (s == SZ_WORD && ad[0])
      return;
    if (ad[15:1] == CTL_A_BASE[15:1])
      ma = (ma & ~m) | (v & 16'h1c02);
    if (ad[15:1] == CTL_B_BASE[15:1])
      mb = (mb & ~m) | (v & 16'h1c00);
  endfunction

  task automatic rd(input logic [15:0] ad, input pmct_size_t s, output logic [31:0] r);
    logic v;
    u_host.access(ad, s, 1'b0, 32'h0, r, v);
    chk("rvalid", 1'b1, v);
  endtask

  task automatic wr(input logic [15:0] ad, input pmct_size_t s, input logic [31:0] dv);
    logic [31:0] r;
    logic        v;
    u_host.access(ad, s, 1'b1, dv, r, v);
    mwr(ad, s, dv[15:0]);
  endtask

  task automatic chk_ctl();
    rd(CTL_A_BASE, SZ_WORD, q);
    chk("ctl_a", {16'h0, ma | {15'h0, mroute}}, q);
    rd(CTL_B_BASE, SZ_WORD, q);
    chk("ctl_b", {16'h0, mb}, q);
    rd(CTL_B_BASE + 16'h1, SZ_BYTE, q);
    chk("ctl_b_hi", {24'h0, mb[15:8]}, q);
  endtask

  task automatic rate();
    logic [31:0] t1, t2;
    int e;
    rd(TMR_BASE, SZ_DWORD, t1);
    repeat (200) @(posedge core_clk);
    rd(TMR_BASE, SZ_DWORD, t2);
    e = 202 * TICK_HZ / CLK_HZ;
    chk("tick_step", 1'b1, (t2 - t1 == e) || (t2 - t1 == e + 1));
    chk("upper_bits", 8'h0, t2[31:24]);
  endtask

  task automatic hold();
    logic [31:0] t1, t2;
    rd(TMR_BASE, SZ_DWORD, t1);
    repeat (50) @(posedge core_clk);
    rd(TMR_BASE, SZ_DWORD, t2);
    chk("count_held", t1, t2);
  endtask

  task automatic pulse(ref logic p);
    p = 1'b1;
    @(posedge core_clk);
    #1;
    p = 1'b0;
  endtask

  initial begin
    {core_clk, rst_n, rset, rclr, fw_en, fw_clr, irq_en, c_clr, idle, bmr, wake} = '0;
    {sclk, irq_en, ma, mb, mroute} = {2'b11, 33'h0};
    void'($urandom(32'h2778));
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk("working", 1'b1, work);
    chk("width", 1'b1, wid);
    chk_ctl();
    for (int i = 0; i < 12; i++) begin
      k = $urandom % 4;
      a = (k[1] ? CTL_B_BASE : CTL_A_BASE) + 16'(k[0]);
      d = (16'($urandom) << (k[0] * 8)) & 16'hdffb;
      wr(a, (k[0] || k[1]) ? SZ_BYTE : SZ_WORD, {16'h0, d >> (k[0] * 8)});
      chk_ctl();
    end
    rd(CTL_A_BASE + 16'h1, SZ_WORD, q);
    chk("odd_word", 32'h0, q);
    rd(CTL_A_BASE + 16'h2, SZ_WORD, q);
    chk("unmapped", 32'h0, q);
    rd(TMR_BASE, SZ_WORD, q);
    chk("tmr_word", 32'h0, q);
    wr(TMR_BASE, SZ_DWORD, 32'hffff_ffff);
    rate();
    pulse(rset);
    mroute = 1'b1;
    chk("route_on", 1'b1, route_q);
    wr(CTL_A_BASE, SZ_WORD, {16'h0, ma | 16'h0001});
    fw_en = 1'b1;
    wr(CTL_A_BASE, SZ_WORD, {16'h0, ma | 16'h0005});
    chk("lock_pulse", 1'b1, lock_q);
    @(posedge core_clk);
    #1;
    chk("fw_flag", 1'b1, fw_f);
    chk("fw_irq", 1'b1, fw_i);
    pulse(fw_clr);
    chk("fw_clear", 1'b0, fw_f);
    chk_ctl();
    pulse(rclr);
    mroute = 1'b0;
    chk("route_off", 1'b0, route_q);
    wr(CTL_A_BASE, SZ_WORD, {16'h0, ma | 16'h0002});
    {idle, bmr} = 2'b11;
    repeat (4) @(posedge core_clk);
    #1;
    chk("bm_wake", 1'b1, pwake & bmw);
    wr(CTL_A_BASE, SZ_WORD, {16'h0, ma & 16'hfffd});
    repeat (4) @(posedge core_clk);
    #1;
    chk("bm_nowake", 1'b0, pwake);
    {idle, bmr, sclk} = 3'b000;
    repeat (4) @(posedge core_clk);
    hold();
    sclk = 1'b1;
    ta = 3'($urandom);
    tb = 3'($urandom);
    wr(CTL_B_BASE, SZ_WORD, {19'h0, tb, 10'h0});
    wr(CTL_A_BASE, SZ_WORD, {18'h1, ta, 10'h0});
    @(posedge core_clk);
    #1;
    chk("sleep_go", 1'b1, go_q);
    chk("asleep", 1'b0, work);
    chk("type_a", ta, ta_q);
    chk("type_b", tb, tb_q);
    @(posedge core_clk);
    #1;
    chk("go_single", 1'b0, go_q);
    hold();
    chk_ctl();
    wake = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    wake = 1'b0;
    chk("awake", 1'b1, work);
    rate();
    chk("carry_idle", 1'b0, car_f);
    chk("os_irq_idle", 1'b0, os_i);
    chk("fw_irq_idle", 1'b0, fw_i);
    complete_run();
  end
endmodule
